// *** rtl/rtc_cal_pkg.sv ***
package rtc_cal_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_CONTROL    = 5'h00;
  localparam logic [4:0] OFS_ALARM_CTRL = 5'h04;
  localparam logic [4:0] OFS_TIME       = 5'h08;
  localparam logic [4:0] OFS_DATE       = 5'h0C;
  localparam logic [4:0] OFS_ALM_TIME   = 5'h10;
  localparam logic [4:0] OFS_ALM_DATE   = 5'h14;
  // Main control register bit positions
  localparam int CTL_ON_BIT     = 15;
  localparam int CTL_UNLOCK_BIT = 3;
  localparam int CTL_SYNC_BIT   = 2;
  localparam int CTL_HALF_BIT   = 1;
  // Alarm control bit positions
  localparam int ALM_EN_BIT     = 15;
  localparam int ALM_CHIME_BIT  = 14;
  localparam int ALM_PULSE_BIT  = 13;
  localparam int ALM_SYNC_BIT   = 12;
  localparam int ALM_MASK_LSB   = 8;
  // Field masks of the value registers
  localparam logic [31:0] TIME_MASK = 32'hFFFFFF00;
  localparam logic [31:0] DATE_MASK = 32'hFFFFFF0F;
  localparam logic [31:0] ADATE_MASK = 32'h00FFFF0F;
  // Reset values
  localparam logic [31:0] TIME_RST = 32'h00000000;
  localparam logic [31:0] DATE_RST = 32'h01010100;
  // Alarm mask codes
  localparam logic [3:0] MASK_HALF_SEC = 4'h0;
  localparam logic [3:0] MASK_SEC      = 4'h1;
  localparam logic [3:0] MASK_TEN_SEC  = 4'h2;
  localparam logic [3:0] MASK_MIN      = 4'h3;
  localparam logic [3:0] MASK_TEN_MIN  = 4'h4;
  localparam logic [3:0] MASK_HOUR     = 4'h5;
  localparam logic [3:0] MASK_DAY      = 4'h6;
  localparam logic [3:0] MASK_WEEK     = 4'h7;
  localparam logic [3:0] MASK_MONTH    = 4'h8;
  localparam logic [3:0] MASK_YEAR     = 4'h9;
  // Timing
  localparam int CLK_HZ        = 20000000;
  localparam int HALF_SEC_MS   = 500;
  localparam int HALF_SEC_CYC  = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int SYNC_WIN_CYC  = 32;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_s;

  typedef struct packed {
    logic [7:0] years;
    logic [7:0] months;
    logic [7:0] days;
    logic [3:0] weekday;
  } date_s;
endpackage

// *** rtl/bcd_digit_step.sv ***
`timescale 1ns/1ps
// Steps a two-digit BCD field, wrapping from max to min
module bcd_digit_step (
  input  wire logic [7:0] cur,
  input  wire logic [7:0] max_val,
  input  wire logic [7:0] min_val,
  input  wire logic       inc,
  output logic      [7:0] nxt,
  output logic            carry
);
  always_comb begin
    nxt   = cur;
    carry = 1'b0;
    if (inc) begin
      if (cur >= max_val) begin
        nxt   = min_val;
        carry = 1'b1;
      end else if (cur[3:0] >= 4'h9) begin
        nxt = {cur[7:4] + 4'h1, 4'h0};
      end else begin
        nxt = {cur[7:4], cur[3:0] + 4'h1};
      end
    end
  end
endmodule

// *** rtl/rtc_calendar_alarm_regs.sv ***
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - Without chime, repeat count N gives N plus one firings
// - Each alarm event decrements a nonzero repeat count
// - Zero wraps to 0xFF only in chime
// - Last firing without chime clears alarm enable
// - Alarm control reset only by power-on
// - Time hours BCD in bits 31-24
// - Time minutes BCD in bits 23-16
// - Time seconds BCD bits 15-8, low zero
// - Time and date writes need write unlock bit
// - Date year BCD in bits 31-24
// - Date month BCD in bits 23-16
// - Date day BCD in bits 15-8
// - Weekday digit bits 3-0, 7-4 zero
// - Alarm time uses current time layout
// - Alarm date month, day, weekday only
// - Four-bit mask selects match granularity
// - Seconds write clears half-second flag
module rtc_calendar_alarm_regs #(
  parameter int HALF_CYCLES = rtc_cal_pkg::HALF_SEC_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             alarm_pulse
);
  import rtc_cal_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  logic [4:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic        wr_fire;
  logic [31:0] wr_mask;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_ok;

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 5'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Rst_b is the power-on reset; no other reset reaches these
  logic        mod_on_r;
  logic        unlock_r;
  logic        alm_en_r;
  logic        chime_r;
  logic        pulse_r;
  logic [3:0]  alarm_match_mask_r;
  logic [7:0]  alarm_repeat_count_r;
  time_s       time_r;
  date_s       date_r;
  time_s       atime_r;
  date_s       adate_r;
  logic        half_r;
  logic [31:0] presc_r;
  logic        sec_tick;
  logic        half_tick;
  logic        alarm_evt;
  logic        unstable;

  logic [31:0] ctl_rd;
  logic [31:0] alm_rd;
  logic [31:0] wr_time;
  logic [31:0] wr_date;
  logic        wr_alm_ctl;
  logic        wr_time_ok;
  logic        wr_date_ok;

  assign unstable = mod_on_r && (presc_r >= 32'(HALF_CYCLES - SYNC_WIN_CYC));
  assign ctl_rd = (32'(mod_on_r) << CTL_ON_BIT) | (32'(unlock_r) << CTL_UNLOCK_BIT)
                | (32'(unstable) << CTL_SYNC_BIT) | (32'(half_r) << CTL_HALF_BIT);
  assign alm_rd = (32'(alm_en_r) << ALM_EN_BIT) | (32'(chime_r) << ALM_CHIME_BIT)
                | (32'(pulse_r) << ALM_PULSE_BIT) | (32'(unstable) << ALM_SYNC_BIT)
                | (32'(alarm_match_mask_r) << ALM_MASK_LSB) | 32'(alarm_repeat_count_r);

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      OFS_CONTROL:    rd_val = ctl_rd;
      OFS_ALARM_CTRL: rd_val = alm_rd;
      OFS_TIME:       rd_val = {time_r, 8'h00};
      OFS_DATE:       rd_val = {date_r[27:4], 4'h0, date_r[3:0]};
      OFS_ALM_TIME:   rd_val = {atime_r, 8'h00};
      OFS_ALM_DATE:   rd_val = {8'h00, adate_r[19:4], 4'h0, adate_r[3:0]};
      default:        rd_ok  = 1'b0;
    endcase
  end

  always_comb begin
    wr_ok = 1'b1;
    case (aw_addr_r)
      OFS_CONTROL, OFS_ALARM_CTRL, OFS_TIME, OFS_DATE, OFS_ALM_TIME, OFS_ALM_DATE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  assign wr_alm_ctl = wr_fire && aw_addr_r == OFS_ALARM_CTRL;
  assign wr_time_ok = wr_fire && aw_addr_r == OFS_TIME && unlock_r;
  assign wr_date_ok = wr_fire && aw_addr_r == OFS_DATE && unlock_r;
  assign wr_time = ({time_r, 8'h00} & ~wr_mask) | (w_data_r & wr_mask & TIME_MASK);
  assign wr_date = ({date_r[27:4], 4'h0, date_r[3:0]} & ~wr_mask)
                 | (w_data_r & wr_mask & DATE_MASK);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mod_on_r <= 1'b0;
      unlock_r <= 1'b0;
    end else if (wr_fire && aw_addr_r == OFS_CONTROL) begin
      unlock_r <= w_data_r[CTL_UNLOCK_BIT];
      if (unlock_r || w_data_r[CTL_UNLOCK_BIT]) begin
        mod_on_r <= w_data_r[CTL_ON_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      atime_r <= '0;
      adate_r <= '0;
    end else if (wr_fire) begin
      if (aw_addr_r == OFS_ALM_TIME) begin
        atime_r <= time_s'((({atime_r, 8'h00} & ~wr_mask) | (w_data_r & wr_mask)) >> 8);
      end
      if (aw_addr_r == OFS_ALM_DATE) begin
        adate_r <= date_s'({8'h00, ((({8'h00, adate_r[19:4], 4'h0, adate_r[3:0]} & ~wr_mask)
                   | (w_data_r & wr_mask & ADATE_MASK)) >> 8), w_data_r[3:0]});
        if (!wr_mask[0]) begin
          adate_r.weekday <= adate_r.weekday;
        end
      end
    end
  end

  // ****************************************
  // Prescaler and calendar
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_r <= 32'h00000000;
      half_r  <= 1'b0;
    end else if (wr_time_ok && wr_mask[8]) begin
      presc_r <= 32'h00000000;
      half_r  <= 1'b0;
    end else if (mod_on_r) begin
      if (half_tick) begin
        presc_r <= 32'h00000000;
        half_r  <= !half_r;
      end else begin
        presc_r <= presc_r + 32'h00000001;
      end
    end
  end

  assign half_tick = mod_on_r && presc_r == 32'(HALF_CYCLES - 1);
  assign sec_tick  = half_tick && half_r;

  logic [7:0] sec_n, min_n, hr_n, day_n, mon_n, yr_n, dim;
  logic       c_sec, c_min, c_hr, c_day, c_mon;

  always_comb begin
    case (date_r.months)
      // Leap when the BCD year is a multiple of four
      8'h02:   dim = (date_r.years[4] ^ date_r.years[1]) || date_r.years[0] ? 8'h28 : 8'h29;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
  end

  bcd_digit_step u_sec (.cur(time_r.seconds), .max_val(8'h59), .min_val(8'h00),
    .inc(sec_tick), .nxt(sec_n), .carry(c_sec));
  bcd_digit_step u_min (.cur(time_r.minutes), .max_val(8'h59), .min_val(8'h00),
    .inc(c_sec), .nxt(min_n), .carry(c_min));
  bcd_digit_step u_hr (.cur(time_r.hours), .max_val(8'h23), .min_val(8'h00),
    .inc(c_min), .nxt(hr_n), .carry(c_hr));
  bcd_digit_step u_day (.cur(date_r.days), .max_val(dim), .min_val(8'h01),
    .inc(c_hr), .nxt(day_n), .carry(c_day));
  bcd_digit_step u_mon (.cur(date_r.months), .max_val(8'h12), .min_val(8'h01),
    .inc(c_day), .nxt(mon_n), .carry(c_mon));
  bcd_digit_step u_yr (.cur(date_r.years), .max_val(8'h99), .min_val(8'h00),
    .inc(c_mon), .nxt(yr_n), .carry());

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      time_r <= time_s'(TIME_RST >> 8);
      date_r <= date_s'({DATE_RST[31:8], DATE_RST[3:0]});
    end else begin
      if (wr_time_ok) begin
        time_r <= time_s'(wr_time >> 8);
      end else begin
        time_r <= '{hours: hr_n, minutes: min_n, seconds: sec_n};
      end
      if (wr_date_ok) begin
        date_r <= date_s'({wr_date[31:8], wr_date[3:0]});
      end else begin
        date_r.years   <= yr_n;
        date_r.months  <= mon_n;
        date_r.days    <= day_n;
        date_r.weekday <= c_hr ? (date_r.weekday >= 4'h6 ? 4'h0 : date_r.weekday + 4'h1)
                               : date_r.weekday;
      end
    end
  end

  // ****************************************
  // Alarm match and repeat counter
  // ****************************************
  logic m_d, m_wd, m_mo, match;

  assign m_d   = date_r.days == adate_r.days;
  assign m_wd  = date_r.weekday == adate_r.weekday;
  assign m_mo  = date_r.months == adate_r.months;

  always_comb begin
    case (alarm_match_mask_r)
      MASK_HALF_SEC: match = half_tick;
      MASK_SEC:      match = sec_tick;
      MASK_TEN_SEC:  match = sec_tick && sec_n[3:0] == atime_r.seconds[3:0];
      MASK_MIN:      match = sec_tick && sec_n == atime_r.seconds;
      MASK_TEN_MIN:  match = sec_tick && sec_n == atime_r.seconds
                             && min_n[3:0] == atime_r.minutes[3:0];
      MASK_HOUR:     match = sec_tick && sec_n == atime_r.seconds && min_n == atime_r.minutes;
      MASK_DAY:      match = sec_tick && {hr_n, min_n, sec_n} == atime_r;
      MASK_WEEK:     match = sec_tick && {hr_n, min_n, sec_n} == atime_r && m_wd;
      MASK_MONTH:    match = sec_tick && {hr_n, min_n, sec_n} == atime_r && m_d;
      MASK_YEAR:     match = sec_tick && {hr_n, min_n, sec_n} == atime_r && m_d && m_mo;
      default:       match = 1'b0;
    endcase
  end

  assign alarm_evt = alm_en_r && match;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alm_en_r <= 1'b0;
      chime_r  <= 1'b0;
      pulse_r  <= 1'b0;
      alarm_match_mask_r  <= 4'h0;
      alarm_repeat_count_r   <= 8'h00;
    end else begin
      if (wr_alm_ctl) begin
        alm_en_r <= w_data_r[ALM_EN_BIT];
        chime_r  <= w_data_r[ALM_CHIME_BIT];
        alarm_match_mask_r  <= w_data_r[ALM_MASK_LSB +: 4];
        alarm_repeat_count_r   <= w_data_r[7:0];
        if (!alm_en_r) begin
          pulse_r <= w_data_r[ALM_PULSE_BIT];
        end
      end
      if (alarm_evt) begin
        pulse_r <= !pulse_r;
        if (alarm_repeat_count_r != 8'h00) begin
          alarm_repeat_count_r <= alarm_repeat_count_r - 8'h01;
        end else if (chime_r) begin
          alarm_repeat_count_r <= 8'hFF;
        end else begin
          alm_en_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_pulse <= 1'b0;
    end else begin
      alarm_pulse <= alarm_evt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_rpt_dec;
    @(posedge core_clk) disable iff (!rst_b)
    alarm_evt && !wr_alm_ctl && alarm_repeat_count_r != 8'h00 |=> alarm_repeat_count_r == $past(alarm_repeat_count_r) - 8'h01;
  endproperty
  a_rpt_dec: assert property (p_rpt_dec) else $error("repeat count not decremented");

  property p_rpt_wrap;
    @(posedge core_clk) disable iff (!rst_b)
    alarm_evt && !wr_alm_ctl && alarm_repeat_count_r == 8'h00 && chime_r |=> alarm_repeat_count_r == 8'hFF && alm_en_r;
  endproperty
  a_rpt_wrap: assert property (p_rpt_wrap) else $error("chime wrap wrong");

  property p_en_clear;
    @(posedge core_clk) disable iff (!rst_b)
    alarm_evt && !wr_alm_ctl && alarm_repeat_count_r == 8'h00 && !chime_r |=> !alm_en_r && alarm_repeat_count_r == 8'h00;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("alarm enable not cleared");

  property p_lock;
    @(posedge core_clk) disable iff (!rst_b)
    wr_fire && aw_addr_r == OFS_TIME && !unlock_r && !sec_tick |=> $stable(time_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked time register written");

  property p_half_clr;
    @(posedge core_clk) disable iff (!rst_b)
    wr_time_ok && w_strb_r[1] |=> !half_r;
  endproperty
  a_half_clr: assert property (p_half_clr) else $error("half-second flag not cleared");

  property p_evt_needs_en;
    @(posedge core_clk) disable iff (!rst_b)
    alarm_evt |-> alm_en_r ##1 alarm_pulse;
  endproperty
  a_evt_needs_en: assert property (p_evt_needs_en) else $error("alarm pulse wrong");

  property p_sec_range;
    @(posedge core_clk) disable iff (!rst_b)
    sec_tick && time_r.seconds == 8'h59 && !wr_time_ok |=> time_r.seconds == 8'h00;
  endproperty
  a_sec_range: assert property (p_sec_range) else $error("seconds did not wrap");

  property p_time_rd;
    @(posedge core_clk) disable iff (!rst_b)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_TIME |=> s_axi_rdata[7:0] == 8'h00;
  endproperty
  a_time_rd: assert property (p_time_rd) else $error("time low byte not zero");
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import rtc_cal_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  localparam int HALF = 64;
  logic        core_clk;
  logic        rst_b;
  logic [4:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [4:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        alarm_pulse;
  int          num_errors;
  int          checks_done;
  int          pulse_cnt = 0;
  logic [31:0] rd;
  logic [1:0]  rsp;

  rtc_calendar_alarm_regs #(.HALF_CYCLES(HALF)) i_rtc_calendar_alarm_regs (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .s_axi_awaddr (awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata  (wdata),
    .s_axi_wstrb  (wstrb),
    .s_axi_wvalid (wvalid),
    .s_axi_wready (wready),
    .s_axi_bresp  (bresp),
    .s_axi_bvalid (bvalid),
    .s_axi_bready (bready),
    .s_axi_araddr (araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata  (rdata),
    .s_axi_rresp  (rresp),
    .s_axi_rvalid (rvalid),
    .s_axi_rready (rready),
    .alarm_pulse  (alarm_pulse)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Counts alarm pulses seen on the output
  always @(posedge core_clk) begin
    if (alarm_pulse === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge core_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge core_clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    chk("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rsp);
    chk(name, rd, exp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_and_map;
    rd_chk("time_rst", OFS_TIME, TIME_RST);
    rd_chk("date_rst", OFS_DATE, DATE_RST);
    rd_chk("alarm_ctrl_rst", OFS_ALARM_CTRL, 32'h00000000);
    axi_rd(5'h18, rd, rsp);
    chk("unmapped_rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("unmapped_rdata", rd, 32'h00000000);
    axi_wr(5'h1C, 32'hFFFFFFFF, rsp);
    chk("unmapped_bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_lock_and_layout;
    wr(OFS_TIME, 32'h12000000);
    rd_chk("time_locked", OFS_TIME, TIME_RST);
    wr(OFS_CONTROL, 32'h00000008);
    wr(OFS_DATE, 32'h241231F6);
    rd_chk("date_layout", OFS_DATE, 32'h24123106);
    wr(OFS_TIME, 32'h235959AB);
    rd_chk("time_layout", OFS_TIME, 32'h23595900);
    wr(OFS_ALM_TIME, 32'h123456FF);
    rd_chk("alm_time", OFS_ALM_TIME, 32'h12345600);
    wr(OFS_ALM_DATE, 32'hAB123106);
    rd_chk("alm_date", OFS_ALM_DATE, 32'h00123106);
  endtask

  task automatic t_rollover;
    wr(OFS_CONTROL, 32'h00008008);
    repeat (HALF * 3) @(posedge core_clk);
    wr(OFS_CONTROL, 32'h00000008);
    rd_chk("time_roll", OFS_TIME, 32'h00000000);
    rd_chk("date_roll", OFS_DATE, 32'h25010100);
  endtask

  task automatic t_repeat_stop;
    int p0;
    wr(OFS_ALARM_CTRL, 32'h00008002);
    p0 = pulse_cnt;
    wr(OFS_CONTROL, 32'h00008008);
    repeat (HALF * 6) @(posedge core_clk);
    wr(OFS_CONTROL, 32'h00000008);
    chk("pulses_n_plus_1", 32'(pulse_cnt - p0), 32'd3);
    rd_chk("alarm_off_at_zero", OFS_ALARM_CTRL, 32'h00002000);
  endtask

  task automatic t_repeat_chime;
    int p;
    int p0;
    wr(OFS_ALARM_CTRL, 32'h0000C001);
    p0 = pulse_cnt;
    wr(OFS_CONTROL, 32'h00008008);
    repeat (HALF * 6) @(posedge core_clk);
    wr(OFS_CONTROL, 32'h00000008);
    repeat (2) @(posedge core_clk);
    p = pulse_cnt - p0;
    chk("chime_wrapped", 32'(p >= 4), 32'd1);
    rd_chk("chime_count", OFS_ALARM_CTRL, {16'h0, 2'b11, 1'(p % 2), 5'h00, 8'(1 - p)});
  endtask

  task automatic t_half_flag;
    int n;
    wr(OFS_CONTROL, 32'h00008008);
    n = 0;
    do begin
      axi_rd(OFS_CONTROL, rd, rsp);
      n++;
    end while (rd[CTL_HALF_BIT] !== 1'b1 && n < 100);
    chk("half_seen", {31'h0, rd[CTL_HALF_BIT]}, 32'h1);
    n = 0;
    do begin
      axi_rd(OFS_CONTROL, rd, rsp);
      n++;
    end while (rd[CTL_SYNC_BIT] !== 1'b1 && n < 100);
    chk("sync_seen", {31'h0, rd[CTL_SYNC_BIT]}, 32'h1);
    wr(OFS_TIME, 32'h10203000);
    axi_rd(OFS_CONTROL, rd, rsp);
    chk("half_cleared", {31'h0, rd[CTL_HALF_BIT]}, 32'h0);
    wr(OFS_CONTROL, 32'h00000008);
  endtask

  // Ten-second mask: from 00:00:08 only the tick to :10 matches
  task automatic t_mask_ten_sec;
    int p0;
    wr(OFS_TIME, 32'h00000800);
    wr(OFS_ALM_TIME, 32'h00000000);
    wr(OFS_ALARM_CTRL, 32'h00000000);
    wr(OFS_ALARM_CTRL, 32'h00008205);
    p0 = pulse_cnt;
    wr(OFS_CONTROL, 32'h00008008);
    repeat (HALF * 6) @(posedge core_clk);
    wr(OFS_CONTROL, 32'h00000008);
    repeat (2) @(posedge core_clk);
    chk("ten_sec_pulses", 32'(pulse_cnt - p0), 32'd1);
    rd_chk("ten_sec_count", OFS_ALARM_CTRL, 32'h0000A204);
  endtask

  // ****************************************
  // Main sequence and verdict
  // ****************************************
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    num_errors  = 0;
    checks_done = 0;
    rst_b   = 1'b0;
    awaddr  = 5'h00;
    awvalid = 1'b0;
    wdata   = 32'h00000000;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 5'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset_and_map();
    t_lock_and_layout();
    t_rollover();
    t_repeat_stop();
    t_repeat_chime();
    t_half_flag();
    t_mask_ten_sec();
    test_done();
  end

  // Cuts a hung handshake short
  initial begin
    #(50 * 40000);
    num_errors++;
    test_done();
  end
endmodule
